// ---- logic/abe_block_enable_control.sv ----
// Analog block enable register bank with temperature conversion control.
// Assumes a single-cycle register port and a converter that pulses done.
//
// Strobed register access and the placing of the registers were left to the implementer.

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Bit 14 enables the waveform generator
// - Bit 13 starts temperature conversion, stores result
// - Bit 12 powers the temperature sensor
// - Temperature reading needs bits 12 and 13
// - Bit 11 enables the fast transimpedance amplifier
// - Bit 10 enables the excitation instrumentation amplifier
// - Bit 9 enables the excitation buffer
// - Bit 8 gates converter conversions
// - Bit 7 powers the converter
// - Bit 6 enables fast DAC, not generator
// - Bit 5 set powers down the reference
module abe_block_enable_control
   import abe_pkg::*;
#(
   parameter int ADDR_W = ABE_ADDR_W,
   parameter int TEMP_W = ABE_TEMP_W
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output wire logic [31:0]       reg_rdata,
   output wire logic              wave_generator_on,
   output wire logic              temp_conversion_trigger,
   output wire logic              temp_sensor_power,
   output wire logic              fast_transimpedance_on,
   output wire logic              excitation_amp_on,
   output wire logic              excitation_buffer_on,
   output wire logic              converter_run,
   output wire logic              converter_power,
   output wire logic              fast_dac_on,
   output wire logic              high_power_ref_off,
   output wire logic              temp_conv_start,
   input  wire logic              temp_conv_done,
   input  wire logic [TEMP_W-1:0] temp_conv_data
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [31:0] cfg;
      logic [31:0] rdata;
      logic        run;
      logic        valid;
   } abe_bank_t;

   abe_bank_t q, d;

   abe_temp_if #(.TEMP_W(TEMP_W)) tif ();

   logic cfg_sel;
   logic cfg_wr;
   logic temp_req;

   ////////////////////////////////////////////////////////////////////////
   // Decode

   assign cfg_sel  = (reg_addr == ADDR_W'(ABE_CFG_OFS));
   assign cfg_wr   = reg_wr && cfg_sel;
   // A conversion is asked for only when the write leaves both bits set
   assign temp_req = cfg_wr && reg_wdata[ABE_TCONV_BIT]
                     && reg_wdata[ABE_TSENS_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d       = q;
      d.rdata = 32'h0000_0000;

      if (cfg_wr) begin
         d.cfg = reg_wdata & ABE_CFG_MASK;
      end

      // Run reaches the converter only while it is powered
      d.run = d.cfg[ABE_RUN_BIT] && d.cfg[ABE_PWR_BIT];

      // Set wins over the clear; a refused request leaves valid alone
      d.valid = tif.done
                || (q.valid && !(temp_req && !tif.busy));

      if (reg_rd) begin
         case (reg_addr)
            ADDR_W'(ABE_CFG_OFS): begin
               d.rdata = q.cfg;
            end
            ADDR_W'(ABE_RESULT_OFS): begin
               d.rdata = 32'(tif.result);
            end
            ADDR_W'(ABE_STATUS_OFS): begin
               d.rdata[ABE_ST_BUSY_BIT]  = tif.busy;
               d.rdata[ABE_ST_VALID_BIT] = q.valid;
            end
            default: begin
               d.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         q <= '{cfg: ABE_CFG_RESET, rdata: 32'h0000_0000, run: 1'b0,
                valid: 1'b0};
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Temperature sequencer

   assign tif.req      = temp_req;
   // Clearing either bit ends a conversion in flight
   assign tif.abort    = !(q.cfg[ABE_TSENS_BIT] && q.cfg[ABE_TCONV_BIT]);
   assign tif.adc_done = temp_conv_done;
   assign tif.adc_data = temp_conv_data;

   abe_temp_seq #(
      .TEMP_W (TEMP_W)
   ) u_temp_seq (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .tif     (tif.seq)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs, each a flip-flop

   assign reg_rdata               = q.rdata;
   assign wave_generator_on       = q.cfg[ABE_WAVE_BIT];
   assign temp_conversion_trigger = q.cfg[ABE_TCONV_BIT];
   assign temp_sensor_power       = q.cfg[ABE_TSENS_BIT];
   assign fast_transimpedance_on  = q.cfg[ABE_TIA_BIT];
   assign excitation_amp_on       = q.cfg[ABE_INAMP_BIT];
   assign excitation_buffer_on    = q.cfg[ABE_EXBUF_BIT];
   assign converter_run           = q.run;
   assign converter_power         = q.cfg[ABE_PWR_BIT];
   // Generator has its own bit; DAC bit leaves it alone
   assign fast_dac_on             = q.cfg[ABE_DAC_BIT];
   // Inverted sense: one means the reference is off
   assign high_power_ref_off      = q.cfg[ABE_REFOFF_BIT];
   assign temp_conv_start         = tif.adc_start;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   sequence cfg_write_s;
      reg_wr && cfg_sel;
   endsequence

   sequence cfg_read_s;
      reg_rd && cfg_sel;
   endsequence

   sequence conv_done_s;
      tif.busy && !tif.abort && temp_conv_done;
   endsequence

   wave_follow_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s |=> wave_generator_on == $past(reg_wdata[ABE_WAVE_BIT]))
      else $error("waveform enable did not follow write");

   temp_result_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      conv_done_s |=> tif.result == $past(temp_conv_data) && tif.done
                      ##1 q.valid)
      else $error("temperature result not captured");

   sensor_power_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s |=> temp_sensor_power == $past(reg_wdata[ABE_TSENS_BIT]))
      else $error("sensor power did not follow write");

   temp_gate_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      temp_conv_start |-> temp_sensor_power && temp_conversion_trigger
                          && $past(temp_req))
      else $error("temperature start without both bits");

   tia_follow_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s |=> fast_transimpedance_on == $past(reg_wdata[ABE_TIA_BIT]))
      else $error("transimpedance enable did not follow write");

   amp_follow_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s |=> excitation_amp_on == $past(reg_wdata[ABE_INAMP_BIT]))
      else $error("instrumentation amp enable did not follow write");

   buffer_follow_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s |=> excitation_buffer_on == $past(reg_wdata[ABE_EXBUF_BIT]))
      else $error("excitation buffer enable did not follow write");

   run_gate_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s |=> converter_run == ($past(reg_wdata[ABE_RUN_BIT])
                      && $past(reg_wdata[ABE_PWR_BIT])))
      else $error("converter runs while unpowered or not enabled");

   power_follow_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s |=> converter_power == $past(reg_wdata[ABE_PWR_BIT]))
      else $error("converter power did not follow write");

   dac_alone_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s |=> fast_dac_on == $past(reg_wdata[ABE_DAC_BIT])
                      && wave_generator_on == $past(reg_wdata[ABE_WAVE_BIT]))
      else $error("DAC enable disturbed the generator");

   ref_sense_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s |=> high_power_ref_off == $past(reg_wdata[ABE_REFOFF_BIT]))
      else $error("reference power-down has wrong sense");

   cfg_read_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_read_s |=> reg_rdata[4:0] == 5'h00 && reg_rdata[31:15] == '0
                     && reg_rdata == q.cfg)
      else $error("configuration read shows reserved bits");

   rdata_idle_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside the read cycle");

   ////////////////////////////////////////////////////////////////////////
   // Checks on the conversion handshake and the other read paths

   sequence result_read_s;
      reg_rd && (reg_addr == ADDR_W'(ABE_RESULT_OFS));
   endsequence

   sequence status_read_s;
      reg_rd && (reg_addr == ADDR_W'(ABE_STATUS_OFS));
   endsequence

   sequence unmapped_read_s;
      reg_rd && !cfg_sel && (reg_addr != ADDR_W'(ABE_RESULT_OFS))
      && (reg_addr != ADDR_W'(ABE_STATUS_OFS));
   endsequence

   // Accepted request: the sequencer is idle exactly while not busy
   sequence conv_request_s;
      temp_req && !tif.busy;
   endsequence

   sequence conv_launch_s;
      temp_conv_start ##1 (tif.busy && !temp_conv_start);
   endsequence

   cfg_mask_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s |=> q.cfg == ($past(reg_wdata) & ABE_CFG_MASK))
      else $error("configuration write kept reserved bits");

   cfg_hold_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !cfg_wr |=> $stable(q.cfg))
      else $error("configuration changed without a write");

   reset_clear_a: assert property (
      @(posedge clk_sys)
      $rose(rst_n) |-> q.cfg == ABE_CFG_RESET && !q.valid
                       && reg_rdata == 32'h0000_0000 && !temp_conv_start)
      else $error("state not cleared by reset");

   trigger_follow_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_write_s |=> temp_conversion_trigger
                      == $past(reg_wdata[ABE_TCONV_BIT]))
      else $error("conversion trigger did not follow write");

   launch_shape_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      conv_request_s |=> conv_launch_s)
      else $error("accepted request did not launch a conversion");

   start_refused_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      temp_req && tif.busy |=> !temp_conv_start)
      else $error("request while busy restarted the converter");

   seq_idle_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !temp_req |=> !temp_conv_start)
      else $error("conversion started without a request");

   busy_start_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      temp_conv_start |-> tif.busy)
      else $error("start pulse while sequencer not busy");

   done_pulse_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      tif.done |=> !tif.done)
      else $error("completion lasted more than one cycle");

   valid_clear_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      temp_req && !tif.busy && !tif.done |=> !q.valid)
      else $error("new conversion left old result valid");

   abort_drop_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      tif.busy && tif.abort |=> !tif.busy)
      else $error("conversion kept running without both bits");

   abort_done_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      tif.abort && temp_conv_done |=> !tif.done)
      else $error("result taken after the conversion was dropped");

   result_read_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      result_read_s |=> reg_rdata == 32'($past(tif.result)))
      else $error("temperature result read wrong");

   status_read_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      status_read_s |=> reg_rdata[ABE_ST_BUSY_BIT] == $past(tif.busy)
                        && reg_rdata[ABE_ST_VALID_BIT] == $past(q.valid)
                        && reg_rdata[31:2] == 30'h0000_0000)
      else $error("status read wrong");

   unmapped_read_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      unmapped_read_s |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read returned data");

endmodule

// ---- logic/abe_pkg.sv ----
// Package for the analog block enable control register bank.
// Assumes one system clock; all users import abe_pkg::*.
package abe_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register bus geometry and map
   localparam int          ABE_ADDR_W     = 8;
   localparam int          ABE_DATA_W     = 32;
   localparam int          ABE_TEMP_W     = 16;
   localparam logic [7:0]  ABE_CFG_OFS    = 8'h00;
   localparam logic [7:0]  ABE_RESULT_OFS = 8'h04;
   localparam logic [7:0]  ABE_STATUS_OFS = 8'h08;

   ////////////////////////////////////////////////////////////////////////
   // Configuration register fields
   localparam int          ABE_WAVE_BIT   = 14;
   localparam int          ABE_TCONV_BIT  = 13;
   localparam int          ABE_TSENS_BIT  = 12;
   localparam int          ABE_TIA_BIT    = 11;
   localparam int          ABE_INAMP_BIT  = 10;
   localparam int          ABE_EXBUF_BIT  = 9;
   localparam int          ABE_RUN_BIT    = 8;
   localparam int          ABE_PWR_BIT    = 7;
   localparam int          ABE_DAC_BIT    = 6;
   localparam int          ABE_REFOFF_BIT = 5;
   localparam logic [31:0] ABE_CFG_MASK   = 32'h0000_7FE0;
   localparam logic [31:0] ABE_CFG_RESET  = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // Status register fields
   localparam int          ABE_ST_BUSY_BIT  = 0;
   localparam int          ABE_ST_VALID_BIT = 1;

   ////////////////////////////////////////////////////////////////////////
   // Temperature conversion sequencer states
   typedef enum logic [1:0] {
      ABE_TS_IDLE,
      ABE_TS_START,
      ABE_TS_WAIT
   } abe_ts_state_t;

endpackage

// ---- logic/abe_temp_if.sv ----
// Interface between the register bank and its temperature sequencer.
// Assumes both ends run on the same system clock.
interface abe_temp_if #(
   parameter int TEMP_W = 16
);
   logic              req;
   logic              abort;
   logic              busy;
   logic              done;
   logic [TEMP_W-1:0] result;
   logic              adc_start;
   logic              adc_done;
   logic [TEMP_W-1:0] adc_data;

   modport ctl (
      output req,
      output abort,
      output adc_done,
      output adc_data,
      input  busy,
      input  done,
      input  result,
      input  adc_start
   );

   modport seq (
      input  req,
      input  abort,
      input  adc_done,
      input  adc_data,
      output busy,
      output done,
      output result,
      output adc_start
   );
endinterface

// ---- logic/abe_temp_seq.sv ----
// Temperature conversion sequencer: one conversion per request.
// Assumes the converter answers a start pulse with a done pulse and data.
module abe_temp_seq
   import abe_pkg::*;
#(
   parameter int TEMP_W = ABE_TEMP_W
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   abe_temp_if.seq   tif
);

   typedef struct packed {
      abe_ts_state_t     state;
      logic              start;
      logic              busy;
      logic              done;
      logic [TEMP_W-1:0] result;
   } abe_ts_t;

   abe_ts_t q, d;

   always_comb begin
      d       = q;
      d.start = 1'b0;
      d.done  = 1'b0;
      case (q.state)
         ABE_TS_IDLE: begin
            // Requests while busy are dropped, not queued
            // Abort lags the write by a cycle, so it cannot veto here
            if (tif.req) begin
               d.state = ABE_TS_START;
               d.start = 1'b1;
               d.busy  = 1'b1;
            end
         end
         ABE_TS_START: begin
            d.state = tif.abort ? ABE_TS_IDLE : ABE_TS_WAIT;
            d.busy  = !tif.abort;
         end
         ABE_TS_WAIT: begin
            if (tif.abort) begin
               d.state = ABE_TS_IDLE;
               d.busy  = 1'b0;
            end else if (tif.adc_done) begin
               d.state  = ABE_TS_IDLE;
               d.busy   = 1'b0;
               d.done   = 1'b1;
               d.result = tif.adc_data;
            end
         end
         default: begin
            d.state = ABE_TS_IDLE;
            d.busy  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         q <= '{state: ABE_TS_IDLE, start: 1'b0, busy: 1'b0, done: 1'b0,
                result: '0};
      end else begin
         q <= d;
      end
   end

   assign tif.adc_start = q.start;
   assign tif.busy      = q.busy;
   assign tif.done      = q.done;
   assign tif.result    = q.result;

   start_single_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      q.start |=> !q.start && (q.busy || tif.abort))
      else $error("conversion start lasted more than one cycle");

endmodule

// ---- tb/abe_block_enable_control_bench.sv ----
// Self-checking bench for the analog block enable register bank.
// Assumes the single-cycle register port and a converter driven by the bench.
module abe_block_enable_control_bench
   import abe_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_sys;
   logic        rst_n;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [9:0]  outs;
   logic        temp_conv_start;
   logic        temp_conv_done;
   logic [15:0] temp_conv_data;
   logic [31:0] rdat;
   int          miscompares;
   int          num_checks;

   abe_block_enable_control u_abe_block_enable_control (
      .clk_sys                 (clk_sys),
      .rst_n                   (rst_n),
      .reg_addr                (reg_addr),
      .reg_wdata               (reg_wdata),
      .reg_wr                  (reg_wr),
      .reg_rd                  (reg_rd),
      .reg_rdata               (reg_rdata),
      .wave_generator_on       (outs[9]),
      .temp_conversion_trigger (outs[8]),
      .temp_sensor_power       (outs[7]),
      .fast_transimpedance_on  (outs[6]),
      .excitation_amp_on       (outs[5]),
      .excitation_buffer_on    (outs[4]),
      .converter_run           (outs[3]),
      .converter_power         (outs[2]),
      .fast_dac_on             (outs[1]),
      .high_power_ref_off      (outs[0]),
      .temp_conv_start         (temp_conv_start),
      .temp_conv_done          (temp_conv_done),
      .temp_conv_data          (temp_conv_data)
   );

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Run gate is power and run together, the rest are plain copies
   function automatic logic [31:0] exp_outs(input logic [31:0] c);
      return {22'h00_0000, c[14:9], c[8] & c[7], c[7:5]};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      #1;
   endtask

   // Data stands one cycle only, then the port returns to zero
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
      @(posedge clk_sys);
      #1;
      chk("rdata idle", 32'h0000_0000, reg_rdata);
   endtask

   task automatic cfg_chk(input logic [31:0] c);
      chk("enable outputs", exp_outs(c), {22'h00_0000, outs});
      rd(ABE_CFG_OFS, rdat);
      chk("cfg readback", c & 32'h0000_7FE0, rdat);
   endtask

   task automatic conv_done(input logic [15:0] d);
      @(posedge clk_sys);
      temp_conv_done <= 1'b1;
      temp_conv_data <= d;
      @(posedge clk_sys);
      temp_conv_done <= 1'b0;
      temp_conv_data <= 16'h0000;
      repeat (2) @(posedge clk_sys);
   endtask

   task automatic end_sim;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #(40 * 4000);
      miscompares++;
      end_sim();
   end

   initial begin
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      temp_conv_done = 1'b0;
      temp_conv_data = 16'h0000;
      miscompares = 0;
      num_checks = 0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      cfg_chk(32'h0000_0000);
      // One enable at a time; lone sensor or trigger must not convert
      for (int i = 5; i < 15; i++) begin
         wr(ABE_CFG_OFS, 32'h0000_0001 << i);
         chk("start idle", 32'h0, {31'h0, temp_conv_start});
         cfg_chk(32'h0000_0001 << i);
      end
      // All ones: reserved bits drop, run gate opens, conversion starts
      wr(ABE_CFG_OFS, 32'hFFFF_FFFF);
      chk("start pulse", 32'h1, {31'h0, temp_conv_start});
      @(posedge clk_sys);
      #1;
      chk("start width", 32'h0, {31'h0, temp_conv_start});
      cfg_chk(32'hFFFF_FFFF);
      rd(ABE_STATUS_OFS, rdat);
      chk("status busy", 32'h0000_0001, rdat);
      wr(ABE_CFG_OFS, 32'h0000_3000);
      chk("no restart busy", 32'h0, {31'h0, temp_conv_start});
      conv_done(16'hA5C3);
      rd(ABE_RESULT_OFS, rdat);
      chk("temp result", 32'h0000_A5C3, rdat);
      rd(ABE_STATUS_OFS, rdat);
      chk("status valid", 32'h0000_0002, rdat);
      // Writes outside the config word are ignored
      wr(ABE_RESULT_OFS, 32'hFFFF_FFFF);
      rd(ABE_RESULT_OFS, rdat);
      chk("result ro", 32'h0000_A5C3, rdat);
      rd(8'hFC, rdat);
      chk("unmapped", 32'h0000_0000, rdat);
      // Clearing the trigger mid-conversion abandons the result
      wr(ABE_CFG_OFS, 32'h0000_3000);
      chk("start again", 32'h1, {31'h0, temp_conv_start});
      wr(ABE_CFG_OFS, 32'h0000_1000);
      conv_done(16'h1234);
      rd(ABE_STATUS_OFS, rdat);
      chk("status abort", 32'h0000_0000, rdat);
      rd(ABE_RESULT_OFS, rdat);
      chk("result kept", 32'h0000_A5C3, rdat);
      cfg_chk(32'h0000_1000);
      // Second reset mid-run clears every enable
      wr(ABE_CFG_OFS, 32'h0000_7FE0);
      chk("all enables", 32'h0000_03FF, {22'h00_0000, outs});
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      cfg_chk(32'h0000_0000);
      rd(ABE_STATUS_OFS, rdat);
      chk("status reset", 32'h0000_0000, rdat);
      end_sim();
   end
endmodule
